// File: rtl/adrc_top.sv
// adrc_top: stereo dynamic range controller with apb registers
// Functional notes
// [RL1] processing only while controller enable set
// [RL2] path select 0 record, 1 playback
// [RL3] signal detect only while its enable set
// [RL4] detect method: crest factor or rms level
// [RL5] rms threshold -27 dB, -1.5 dB per code
// [RL6] crest threshold 14, 20, 26, 32 dB
// [RL7] noise gate only while gate enable set
// [RL8] second knee level honoured only when enabled
// [RL9] quick release enabled after reset
// [RL10] anti-clip enabled after reset
// [RL11] attack 181 us per 6 dB, doubling
// [RL12] decay 1.45 ms per 6 dB, doubling
// [RL13] attenuation floor from min gain code
// [RL14] boost ceiling from max gain code
// [RL15] gate active uses gate min gain floor
// [RL16] quick release threshold 12 to 30 dB
// [RL17] quick release decay 0.725, 1.45, 5.8 ms
// [RL18] gate expansion slope 1, 2, 4, 8
// [RL19] upper slope 1 to 1/16, or 0
// [RL20] lower slope 1 to 1/8, or 0
// [RL21] second knee output -30 dB, -1.5 per code
// [RL22] quick release swaps decay for fast decay
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module adrc_top #(
    parameter int unsigned DECAY_STEP_CYCLES = adrc_pkg::DCY_STEP_CYC,
    parameter int unsigned QR_STEP_CYCLES = adrc_pkg::QR_STEP_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // audio streams
    input wire logic sampleValid,
    input wire adrc_pkg::adrc_stereo_t recIn,
    input wire adrc_pkg::adrc_stereo_t playIn,
    output var adrc_pkg::adrc_stereo_t recOut,
    output var adrc_pkg::adrc_stereo_t playOut,
    output logic outValid,
    // status
    output logic signalDetect,
    output logic gateActive
);
    function automatic logic [22:0] magOf(input adrc_pkg::adrc_smp_t s);
        logic [23:0] a;
        a = s[23] ? -s : s;
        magOf = a[23] ? '1 : a[22:0];
    endfunction

    // coarse log: 6 dB per bit plus a 3 dB half step
    function automatic adrc_pkg::adrc_db_t levelOf(input logic [22:0] m);
        adrc_pkg::adrc_db_t r;
        r = m[0] ? adrc_pkg::LEVEL_LSB : adrc_pkg::LEVEL_FLOOR;
        for (int i = 1; i <= adrc_pkg::BITS_TOP; i++)
        begin
            if (m[i])
            begin
                r = adrc_pkg::adrc_db_t'((i - adrc_pkg::BITS_TOP) * 12);
                if (m[i-1])
                begin
                    r = r + adrc_pkg::DB_STEP_3;
                end
            end
        end
        levelOf = r;
    endfunction

    function automatic adrc_pkg::adrc_db_t scaleDb(input logic [4:0] c,
        input adrc_pkg::adrc_db_t step);
        adrc_pkg::adrc_db_t cs;
        cs = {7'h0, c};
        scaleDb = cs * step;
    endfunction

    // reserved codes at or above the zero code also give slope 0
    function automatic adrc_pkg::adrc_db_t slopeOf(
        input adrc_pkg::adrc_db_t d, input logic [2:0] code,
        input logic [2:0] zeroCode);
        slopeOf = (code >= zeroCode) ? 12'sh000 : (d >>> code);
    endfunction

    function automatic adrc_pkg::adrc_smp_t applyGain(
        input adrc_pkg::adrc_smp_t s, input adrc_pkg::adrc_db_t g);
        logic [7:0] off;
        logic [3:0] q;
        logic [3:0] r;
        logic signed [40:0] p;
        logic signed [52:0] w;
        off = 8'(g + adrc_pkg::GAIN_OFFSET);
        q = 4'(off / 8'h0c);
        r = 4'(off % 8'h0c);
        p = s * $signed({1'b0, adrc_pkg::MANT_TBL[r]});
        w = (53'(p) <<< q) >>> adrc_pkg::MULT_SHIFT;
        if (w > 53'sh7fffff)
        begin
            applyGain = 24'sh7fffff;
        end
        else if (w < -53'sh800000)
        begin
            applyGain = -24'sh800000;
        end
        else
        begin
            applyGain = 24'(w);
        end
    endfunction

    logic [1:0] rstSync_q;
    logic rstLocal;
    adrc_pkg::adrc_cfg1_t cfg1_q;
    adrc_pkg::adrc_cfg2_t cfg2_q;
    adrc_pkg::adrc_cfg3_t cfg3_q;
    adrc_pkg::adrc_knee_t knee_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [22:0] peakEnv_q;
    logic [22:0] avgEnv_q;
    adrc_pkg::adrc_db_t gain_q;
    logic [31:0] stepCnt_q;
    adrc_pkg::adrc_stereo_t recOut_q;
    adrc_pkg::adrc_stereo_t playOut_q;
    logic outValid_q;
    logic sigDet_q;
    logic gateAct_q;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync_q <= 2'h0;
        end
        else
        begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstLocal = rstSync_q[1];

    // apb decode; answer comes in the first access cycle
    wire logic setupPh = psel && !penable;
    wire logic wrEn = psel && penable && pready_q && pwrite;
    wire logic hit1 = paddr == adrc_pkg::ADDR_CFG1;
    wire logic hit2 = paddr == adrc_pkg::ADDR_CFG2;
    wire logic hit3 = paddr == adrc_pkg::ADDR_CFG3;
    wire logic hitK = paddr == adrc_pkg::ADDR_KNEE;
    wire logic hitS = paddr == adrc_pkg::ADDR_STAT;
    wire logic mapped = hit1 || hit2 || hit3 || hitK || hitS;
    wire logic [15:0] statWord = {gain_q, 2'h0, gateAct_q, sigDet_q};
    wire logic [15:0] rdHalf = hit1 ? cfg1_q : hit2 ? cfg2_q :
        hit3 ? cfg3_q : hitK ? knee_q : hitS ? statWord : 16'h0000;

    always_ff @(posedge clk_sys or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setupPh;
            pslverr_q <= setupPh && !mapped;
            prdata_q <= (setupPh && !pwrite) ? {16'h0000, rdHalf} : 32'h0;
        end
    end

    // enables and defaults come up as the reset words say
    always_ff @(posedge clk_sys or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            cfg1_q <= adrc_pkg::CFG1_RST; // [RL1] [RL3] [RL7] [RL9] [RL10]
            cfg2_q <= adrc_pkg::CFG2_RST; // [RL11] [RL12] [RL13] [RL14]
            cfg3_q <= adrc_pkg::CFG3_RST;
            knee_q <= adrc_pkg::KNEE_RST; // [RL8]
        end
        else if (wrEn)
        begin
            if (hit1)
                cfg1_q <= pwdata[15:0] & adrc_pkg::CFG1_MASK;
            if (hit2)
                cfg2_q <= pwdata[15:0] & adrc_pkg::CFG2_MASK;
            if (hit3)
                cfg3_q <= pwdata[15:0];
            if (hitK)
                knee_q <= pwdata[15:0] & adrc_pkg::KNEE_MASK;
        end
    end

    // source of the controlled path, and envelopes from it
    wire logic en = cfg1_q.rangeCtrlEnable;
    wire logic pathSel = cfg1_q.rangeCtrlPathSelect;
    wire adrc_pkg::adrc_stereo_t srcIn = pathSel ? playIn : recIn; // [RL2]
    wire logic [22:0] magL = magOf(srcIn.left);
    wire logic [22:0] magR = magOf(srcIn.right);
    wire logic [22:0] magMax = (magL > magR) ? magL : magR;
    wire logic [22:0] peakFall =
        peakEnv_q - (peakEnv_q >> adrc_pkg::PEAK_FALL_SHIFT);
    wire logic signed [23:0] avgDelta =
        $signed({1'b0, magMax}) - $signed({1'b0, avgEnv_q});
    wire logic [22:0] avgNext =
        avgEnv_q + 23'(avgDelta >>> adrc_pkg::AVG_SHIFT);

    always_ff @(posedge clk_sys or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            peakEnv_q <= 23'h0;
            avgEnv_q <= 23'h0;
        end
        else if (sampleValid)
        begin
            peakEnv_q <= (magMax > peakFall) ? magMax : peakFall;
            avgEnv_q <= avgNext;
        end
    end

    // levels, crest factor and detection thresholds
    wire adrc_pkg::adrc_db_t instLvl = levelOf(magMax);
    wire adrc_pkg::adrc_db_t envLvl = levelOf(peakEnv_q);
    wire adrc_pkg::adrc_db_t avgLvl = levelOf(avgEnv_q);
    wire adrc_pkg::adrc_db_t crest = envLvl - avgLvl;
    wire adrc_pkg::adrc_db_t rmsThr = adrc_pkg::RMS_THR_TOP -
        scaleDb(cfg1_q.detectRmsThreshold, adrc_pkg::DB_STEP_1P5); // [RL5]
    wire adrc_pkg::adrc_db_t pkThr = adrc_pkg::PK_THR_BASE +
        scaleDb({3'h0, cfg1_q.detectCrestThreshold},
        adrc_pkg::DB_STEP_6); // [RL6]
    wire logic detNow = cfg1_q.signalDetectMethod ?
        (avgLvl >= rmsThr) : (crest >= pkThr); // [RL4]

    // static curve: two compressor slopes around the knee
    wire adrc_pkg::adrc_db_t hiOut = adrc_pkg::KNEE_OUT +
        slopeOf(envLvl - adrc_pkg::KNEE_IN, cfg3_q.upperCompressSlope,
        adrc_pkg::HI_ZERO_CODE); // [RL19]
    wire adrc_pkg::adrc_db_t loOut = adrc_pkg::KNEE_OUT -
        slopeOf(adrc_pkg::KNEE_IN - envLvl, cfg3_q.lowerCompressSlope,
        adrc_pkg::LO_ZERO_CODE); // [RL20]
    wire adrc_pkg::adrc_db_t curveOut =
        (envLvl > adrc_pkg::KNEE_IN) ? hiOut : loOut;

    // noise gate below the second knee
    wire adrc_pkg::adrc_db_t k2In = adrc_pkg::K2_IN_TOP -
        scaleDb(knee_q.gateKneeIn, adrc_pkg::DB_STEP_1P5);
    wire adrc_pkg::adrc_db_t k2Curve = adrc_pkg::KNEE_OUT -
        slopeOf(adrc_pkg::KNEE_IN - k2In, cfg3_q.lowerCompressSlope,
        adrc_pkg::LO_ZERO_CODE);
    wire adrc_pkg::adrc_db_t k2Level = adrc_pkg::K2_OUT_TOP -
        scaleDb(knee_q.secondKneeOutLevel, adrc_pkg::DB_STEP_1P5); // [RL21]
    // without the enable the gate joins the curve with no step
    wire adrc_pkg::adrc_db_t k2Base =
        cfg1_q.secondKneeOutEnable ? k2Level : k2Curve; // [RL8] [RL21]
    wire logic gateNow =
        cfg1_q.noiseGateEnable && (envLvl < k2In); // [RL7]
    wire adrc_pkg::adrc_db_t gateOut =
        k2Base - ((k2In - envLvl) <<< cfg3_q.gateExpansionSlope); // [RL18]
    wire adrc_pkg::adrc_db_t outLvl = gateNow ? gateOut : curveOut;
    wire adrc_pkg::adrc_db_t rawGain = outLvl - envLvl;

    // gain limits
    wire logic [2:0] minCode = (cfg2_q.minGainLimit > adrc_pkg::MIN_GAIN_TOP)
        ? adrc_pkg::MIN_GAIN_DFLT : cfg2_q.minGainLimit;
    wire logic [3:0] gateCode = (cfg3_q.gateMinGain > adrc_pkg::GATE_MIN_TOP)
        ? adrc_pkg::GATE_MIN_TOP : cfg3_q.gateMinGain;
    wire adrc_pkg::adrc_db_t minGain =
        adrc_pkg::MIN_GAIN_TBL[minCode]; // [RL13]
    wire adrc_pkg::adrc_db_t gateMin = adrc_pkg::GATE_MIN_BASE +
        scaleDb({1'b0, gateCode}, adrc_pkg::DB_STEP_6); // [RL15]
    wire adrc_pkg::adrc_db_t maxGain =
        adrc_pkg::MAX_GAIN_TBL[cfg2_q.maxGainLimit]; // [RL14]
    wire adrc_pkg::adrc_db_t gainFloor =
        gateNow ? gateMin : minGain; // [RL13] [RL15]
    wire adrc_pkg::adrc_db_t clipCap = -instLvl;
    wire adrc_pkg::adrc_db_t capped =
        (cfg1_q.antiClipEnable && rawGain > clipCap) ? clipCap : rawGain;
    wire adrc_pkg::adrc_db_t belowCeil =
        (capped > maxGain) ? maxGain : capped; // [RL14]
    // the floor wins where a gate floor sits above the ceiling
    wire adrc_pkg::adrc_db_t target =
        (belowCeil < gainFloor) ? gainFloor : belowCeil; // [RL13]

    // step periods per half-dB
    wire logic [3:0] atkCode =
        (cfg2_q.attackRate < adrc_pkg::ATK_CODE_LO) ? adrc_pkg::ATK_CODE_LO :
        (cfg2_q.attackRate > adrc_pkg::ATK_CODE_HI) ? adrc_pkg::ATK_CODE_HI :
        cfg2_q.attackRate;
    wire logic [31:0] atkPeriod =
        adrc_pkg::ATK_STEP_CYC << (atkCode - 4'h1); // [RL11]
    wire logic [31:0] dcyPeriod =
        DECAY_STEP_CYCLES << cfg2_q.decayRate; // [RL12]
    wire logic [31:0] qrPeriod = QR_STEP_CYCLES <<
        adrc_pkg::QR_SHIFT_TBL[cfg3_q.quickReleaseDecay]; // [RL17]
    wire adrc_pkg::adrc_db_t qrThr = adrc_pkg::QR_THR_BASE +
        scaleDb({3'h0, cfg3_q.quickReleaseThreshold},
        adrc_pkg::DB_STEP_6); // [RL16]
    wire logic qrNow = cfg1_q.quickReleaseEnable && (crest > qrThr);
    wire logic attackDir = target < gain_q;
    wire logic [31:0] stepPeriod = attackDir ? atkPeriod :
        qrNow ? qrPeriod : dcyPeriod; // [RL22]
    wire logic stepDue = (stepCnt_q + 32'h1) >= stepPeriod;

    // gain walks one half-dB per elapsed period toward target
    always_ff @(posedge clk_sys or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            gain_q <= 12'sh000;
            stepCnt_q <= 32'h0;
        end
        else if (!en || target == gain_q)
        begin
            gain_q <= en ? gain_q : 12'sh000; // [RL1]
            stepCnt_q <= 32'h0;
        end
        else if (stepDue)
        begin
            gain_q <= attackDir ? gain_q - 12'sh001 : gain_q + 12'sh001;
            stepCnt_q <= 32'h0;
        end
        else
        begin
            stepCnt_q <= stepCnt_q + 32'h1;
        end
    end

    // gain applied to the selected path only
    wire adrc_pkg::adrc_stereo_t procOut =
        {applyGain(srcIn.left, gain_q), applyGain(srcIn.right, gain_q)};
    wire logic doRec = en && !pathSel;
    wire logic doPlay = en && pathSel;

    always_ff @(posedge clk_sys or negedge rstLocal)
    begin
        if (!rstLocal)
        begin
            recOut_q <= '0;
            playOut_q <= '0;
            outValid_q <= 1'b0;
            sigDet_q <= 1'b0;
            gateAct_q <= 1'b0;
        end
        else
        begin
            outValid_q <= sampleValid;
            if (sampleValid)
            begin
                recOut_q <= doRec ? procOut : recIn; // [RL1] [RL2]
                playOut_q <= doPlay ? procOut : playIn; // [RL2]
            end
            sigDet_q <= en && cfg1_q.signalDetectEnable && detNow; // [RL3]
            gateAct_q <= en && gateNow; // [RL7]
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign recOut = recOut_q;
    assign playOut = playOut_q;
    assign outValid = outValid_q;
    assign signalDetect = sigDet_q;
    assign gateActive = gateAct_q;

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstLocal);

    a_bypass_off: assert property ( // [RL1]
        (sampleValid && !en) |=> outValid && recOut == $past(recIn)
            && playOut == $past(playIn))
        else $error("disabled controller altered audio");
    a_path_route: assert property ( // [RL2]
        (sampleValid && en) |=> ($past(pathSel) ?
            recOut == $past(recIn) : playOut == $past(playIn)))
        else $error("unselected path was altered");
    a_detect_gate: assert property ( // [RL3]
        !cfg1_q.signalDetectEnable |=> !signalDetect)
        else $error("signal detect while disabled");
    a_detect_rms: assert property ( // [RL4] [RL5]
        (en && cfg1_q.signalDetectEnable && cfg1_q.signalDetectMethod
            && avgLvl >= rmsThr) |=> signalDetect)
        else $error("rms level above threshold not detected");
    a_reset_defaults: assert property ( // [RL9] [RL10]
        $rose(rstLocal) |-> cfg1_q == adrc_pkg::CFG1_RST
            && cfg2_q == adrc_pkg::CFG2_RST)
        else $error("control words not at reset values");
    a_gate_enable: assert property ( // [RL7]
        !cfg1_q.noiseGateEnable |=> !gateActive)
        else $error("gate active while disabled");
    a_target_limits: assert property ( // [RL13] [RL14] [RL15]
        en |-> target >= gainFloor
            && (target <= maxGain || target == gainFloor))
        else $error("gain target outside limits");
    a_gain_pace: assert property ( // [RL11] [RL12]
        (en && gain_q != $past(gain_q)) |->
            $past(stepCnt_q) + 32'h1 >= $past(stepPeriod)
            && (gain_q - $past(gain_q) == 12'sh001
            || $past(gain_q) - gain_q == 12'sh001))
        else $error("gain stepped early or by more than one");
    a_qr_decay: assert property ( // [RL22]
        (en && !attackDir && target != gain_q && qrNow) |->
            stepPeriod == qrPeriod)
        else $error("quick release rate not used");
endmodule
`default_nettype wire

// File: rtl/adrc_pkg.sv
// adrc_pkg: register map, field layouts and level/timing constants
`default_nettype none
package adrc_pkg;
    typedef logic signed [23:0] adrc_smp_t;
    // levels and gains in half-dB units
    typedef logic signed [11:0] adrc_db_t;
    typedef struct packed {
        adrc_smp_t left;
        adrc_smp_t right;
    } adrc_stereo_t;
    typedef struct packed {
        logic rsvd;
        logic [4:0] detectRmsThreshold;
        logic [1:0] detectCrestThreshold;
        logic noiseGateEnable;
        logic signalDetectMethod;
        logic signalDetectEnable;
        logic secondKneeOutEnable;
        logic quickReleaseEnable;
        logic antiClipEnable;
        logic rangeCtrlPathSelect;
        logic rangeCtrlEnable;
    } adrc_cfg1_t;
    typedef struct packed {
        logic [2:0] rsvd;
        logic [3:0] attackRate;
        logic [3:0] decayRate;
        logic [2:0] minGainLimit;
        logic [1:0] maxGainLimit;
    } adrc_cfg2_t;
    typedef struct packed {
        logic [3:0] gateMinGain;
        logic [1:0] quickReleaseThreshold;
        logic [1:0] quickReleaseDecay;
        logic [1:0] gateExpansionSlope;
        logic [2:0] upperCompressSlope;
        logic [2:0] lowerCompressSlope;
    } adrc_cfg3_t;
    typedef struct packed {
        logic [5:0] rsvd;
        logic [4:0] gateKneeIn;
        logic [4:0] secondKneeOutLevel;
    } adrc_knee_t;
    localparam logic [11:0] IDX_CFG1 = 12'h114;
    localparam logic [11:0] IDX_CFG2 = 12'h115;
    localparam logic [11:0] IDX_CFG3 = 12'h116;
    localparam logic [11:0] IDX_KNEE = 12'h118;
    localparam logic [11:0] IDX_STAT = 12'h11f;
    localparam logic [11:0] ADDR_CFG1 = IDX_CFG1 << 2;
    localparam logic [11:0] ADDR_CFG2 = IDX_CFG2 << 2;
    localparam logic [11:0] ADDR_CFG3 = IDX_CFG3 << 2;
    localparam logic [11:0] ADDR_KNEE = IDX_KNEE << 2;
    localparam logic [11:0] ADDR_STAT = IDX_STAT << 2;
    localparam logic [15:0] CFG1_RST = 16'h000c;
    localparam logic [15:0] CFG2_RST = 16'h0925;
    localparam logic [15:0] CFG3_RST = 16'h0000;
    localparam logic [15:0] KNEE_RST = 16'h0000;
    localparam logic [15:0] CFG1_MASK = 16'h7fff;
    localparam logic [15:0] CFG2_MASK = 16'h1fff;
    localparam logic [15:0] KNEE_MASK = 16'h03ff;
    localparam adrc_db_t LEVEL_FLOOR = -12'sh114;
    localparam adrc_db_t LEVEL_LSB = -12'sh108;
    localparam adrc_db_t DB_STEP_6 = 12'sh00c;
    localparam adrc_db_t DB_STEP_3 = 12'sh006;
    localparam adrc_db_t DB_STEP_1P5 = 12'sh003;
    localparam adrc_db_t RMS_THR_TOP = -12'sh036;
    localparam adrc_db_t PK_THR_BASE = 12'sh01c;
    localparam adrc_db_t QR_THR_BASE = 12'sh018;
    localparam adrc_db_t K2_OUT_TOP = -12'sh03c;
    localparam adrc_db_t K2_IN_TOP = -12'sh048;
    localparam adrc_db_t KNEE_IN = 12'sh000;
    localparam adrc_db_t KNEE_OUT = 12'sh000;
    localparam adrc_db_t GATE_MIN_BASE = -12'sh048;
    localparam adrc_db_t GAIN_OFFSET = 12'sh048;
    localparam adrc_db_t MIN_GAIN_TBL [0:4] = '{12'sh000, -12'sh018,
        -12'sh024, -12'sh030, -12'sh048};
    localparam adrc_db_t MAX_GAIN_TBL [0:3] = '{12'sh018, 12'sh024,
        12'sh030, 12'sh048};
    localparam logic [15:0] MANT_TBL [0:11] = '{16'h8000, 16'h879c,
        16'h8fad, 16'h9838, 16'ha145, 16'haadc, 16'hb505, 16'hbfc9,
        16'hcb30, 16'hd745, 16'he412, 16'hf1a2};
    localparam logic [1:0] QR_SHIFT_TBL [0:3] = '{2'h0, 2'h1, 2'h3, 2'h3};
    localparam logic [2:0] MIN_GAIN_TOP = 3'h4;
    localparam logic [2:0] MIN_GAIN_DFLT = 3'h1;
    localparam logic [3:0] GATE_MIN_TOP = 4'hb;
    localparam logic [3:0] ATK_CODE_LO = 4'h1;
    localparam logic [3:0] ATK_CODE_HI = 4'hb;
    localparam logic [2:0] HI_ZERO_CODE = 3'h5;
    localparam logic [2:0] LO_ZERO_CODE = 3'h4;
    localparam int BITS_TOP = 22;
    localparam int PEAK_FALL_SHIFT = 8;
    localparam int AVG_SHIFT = 6;
    localparam int MULT_SHIFT = 21;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEPS_PER_6DB = 12;
    localparam int unsigned ATK_BASE_NS = 181000;
    localparam int unsigned DCY_BASE_NS = 1450000;
    localparam int unsigned QR_BASE_NS = 725000;
    localparam int unsigned ATK_STEP_CYC =
        ATK_BASE_NS / (CLK_PERIOD_NS * STEPS_PER_6DB);
    localparam int unsigned DCY_STEP_CYC =
        DCY_BASE_NS / (CLK_PERIOD_NS * STEPS_PER_6DB);
    localparam int unsigned QR_STEP_CYC =
        QR_BASE_NS / (CLK_PERIOD_NS * STEPS_PER_6DB);
endpackage
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench for the stereo range controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sampleValid = 1'b0;
    adrc_pkg::adrc_stereo_t recIn = '0;
    adrc_pkg::adrc_stereo_t playIn = '0;
    adrc_pkg::adrc_stereo_t recOut;
    adrc_pkg::adrc_stereo_t playOut;
    logic outValid;
    logic signalDetect;
    logic gateActive;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int total_checks = 0;

    always #5 clk_sys = ~clk_sys;

    // short decay counts keep the run brief
    adrc_top #(.DECAY_STEP_CYCLES(4), .QR_STEP_CYCLES(2)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid),
        .recIn(recIn), .playIn(playIn), .recOut(recOut),
        .playOut(playOut), .outValid(outValid),
        .signalDetect(signalDetect), .gateActive(gateActive)
    );

    task automatic chk(input string nm, input logic [47:0] exp,
        input logic [47:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no local limit: only the watchdog ends a stuck transfer
        while (pready !== 1'b1)
        begin
            @(posedge clk_sys);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, exp, rd);
        chk("pslverr", 1'b0, err);
    endtask

    task automatic smp(input logic [47:0] r, input logic [47:0] p);
        @(posedge clk_sys);
        sampleValid <= 1'b1;
        recIn <= r;
        playIn <= p;
        @(posedge clk_sys);
        sampleValid <= 1'b0;
        @(posedge clk_sys);
        chk("outValid", 1'b1, outValid);
    endtask

    task automatic feed(input int n, input logic [23:0] v);
        repeat (n)
        begin
            @(posedge clk_sys);
            sampleValid <= 1'b1;
            recIn <= {v, v};
        end
        @(posedge clk_sys);
        sampleValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic t_reset;
        chk("signalDetect", 1'b0, signalDetect);
        chk("gateActive", 1'b0, gateActive);
        chk("pready", 1'b0, pready);
        rdc("cfg1", adrc_pkg::ADDR_CFG1, 32'h0000000c);
        rdc("cfg2", adrc_pkg::ADDR_CFG2, 32'h00000925);
        rdc("cfg3", adrc_pkg::ADDR_CFG3, 32'h00000000);
        rdc("knee", adrc_pkg::ADDR_KNEE, 32'h00000000);
        $display("t_reset done");
    endtask

    task automatic t_regs;
        wr(12'h500, 32'h0000ffff);
        chk("unmapped err", 1'b1, err);
        apb(1'b0, 12'h500, 32'h0, rd, err);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped err", 1'b1, err);
        wr(adrc_pkg::ADDR_CFG2, 32'h0000ffff);
        rdc("cfg2", adrc_pkg::ADDR_CFG2, {16'h0, adrc_pkg::CFG2_MASK});
        wr(adrc_pkg::ADDR_CFG3, 32'h0000ffff);
        rdc("cfg3", adrc_pkg::ADDR_CFG3, 32'h0000ffff);
        wr(adrc_pkg::ADDR_CFG1, 32'h0000ffff);
        rdc("cfg1", adrc_pkg::ADDR_CFG1, {16'h0, adrc_pkg::CFG1_MASK});
        // no samples yet, so the level sits below the gate knee
        chk("gateActive", 1'b1, gateActive);
        rdc("status", adrc_pkg::ADDR_STAT, 32'h00000002);
        wr(adrc_pkg::ADDR_KNEE, 32'h0000ffff);
        rdc("knee", adrc_pkg::ADDR_KNEE, {16'h0, adrc_pkg::KNEE_MASK});
        wr(adrc_pkg::ADDR_CFG2, {16'h0, adrc_pkg::CFG2_RST});
        wr(adrc_pkg::ADDR_CFG3, 32'h0);
        $display("t_regs done");
    endtask

    task automatic t_bypass;
        wr(adrc_pkg::ADDR_CFG1, 32'h00000020);
        smp(48'h123456fedcba, 48'h0a0b0cf0f1f2);
        chk("recOut", 48'h123456fedcba, recOut);
        chk("playOut", 48'h0a0b0cf0f1f2, playOut);
        feed(100, 24'h3fffff);
        chk("signalDetect", 1'b0, signalDetect);
        chk("gateActive", 1'b0, gateActive);
        $display("t_bypass done");
    endtask

    // the path not selected must pass untouched whatever the gain
    task automatic t_path;
        wr(adrc_pkg::ADDR_CFG1, 32'h00000001);
        smp(48'h111111222222, 48'h345678876543);
        // gain still at 0 dB right after enable, so unity
        chk("recOut", 48'h111111222222, recOut);
        chk("playOut", 48'h345678876543, playOut);
        wr(adrc_pkg::ADDR_CFG1, 32'h00000003);
        smp(48'h765432abcdef, 48'h010203040506);
        chk("recOut", 48'h765432abcdef, recOut);
        $display("t_path done");
    endtask

    task automatic t_detect;
        wr(adrc_pkg::ADDR_CFG1, 32'h00000061);
        feed(600, 24'h3fffff);
        chk("signalDetect", 1'b1, signalDetect);
        feed(600, 24'h000000);
        chk("signalDetect", 1'b0, signalDetect);
        wr(adrc_pkg::ADDR_CFG1, 32'h00000041);
        feed(50, 24'h3fffff);
        chk("signalDetect", 1'b0, signalDetect);
        $display("t_detect done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset;
        t_regs;
        t_bypass;
        t_path;
        t_detect;
        close_out;
    end

    // run needs about 1450 cycles; allow nearly seven times that
    initial
    begin
        #100000;
        $display("[FAIL] watchdog expected done seen timeout");
        n_mismatch++;
        close_out;
    end
endmodule
`default_nettype wire
